// ===== hw/clrc_pkg.sv
/*
 * Shared constants for the cache lock and replacement controller.
 * Assumes a single clock domain and a 32-bit APB register bus.
 */
package clrc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CLRC_LOCK_CTRL_OFF = 12'h0000;
	localparam logic [11:0] CLRC_STATUS_OFF    = 12'h0004;
	localparam int          CLRC_SEL_BIT       = 28;
	localparam int          CLRC_IEN_BIT       = 27;
	localparam int          CLRC_DEN_BIT       = 26;
	localparam int          CLRC_SEN_BIT       = 25;
	localparam logic [3:0]  CLRC_LOCK_RST      = 4'h0;

	// ----------------------------------------------------------------
	// Cache geometry
	// ----------------------------------------------------------------
	localparam int CLRC_WAYS      = 4;
	localparam int CLRC_P_DEPTH   = 128;
	localparam int CLRC_S_DEPTH   = 2048;
	localparam int CLRC_LINE_B    = 32;
	localparam int CLRC_PTAG_W    = 24;
	localparam int CLRC_ITAG_CTL  = 3;
	localparam int CLRC_IREAD_W   = 64;
	localparam int CLRC_LOCK_KB_P = 8;
	localparam int CLRC_LOCK_KB_S = 128;
	localparam int CLRC_UNC_MAX   = 4;
	localparam int CLRC_SLINE_MAX = 4;

	// ----------------------------------------------------------------
	// Caches, operations, attributes and line states
	// ----------------------------------------------------------------
	localparam logic [1:0] CLRC_IC = 2'h0;
	localparam logic [1:0] CLRC_DC = 2'h1;
	localparam logic [1:0] CLRC_SC = 2'h2;

	typedef enum logic [2:0] {
		CLRC_OP_LOAD     = 3'b000,
		CLRC_OP_STORE    = 3'b001,
		CLRC_OP_FILL_I   = 3'b010,
		CLRC_OP_STHIT    = 3'b011,
		CLRC_OP_TAGW     = 3'b100,
		CLRC_OP_INVAL    = 3'b101,
		CLRC_OP_WB       = 3'b110,
		CLRC_OP_WB_INVAL = 3'b111
	} clrc_op_type;

	localparam logic [2:0] CLRC_ATTR_UNC = 3'h2;
	localparam logic [2:0] CLRC_ATTR_WB  = 3'h3;
	localparam logic [2:0] CLRC_ATTR_BYP = 3'h7;

	localparam logic [1:0] CLRC_P_VALID  = 2'h3;
	localparam logic [1:0] CLRC_S_DEX    = 2'h3;
	localparam logic [1:0] CLRC_S_DEX_D  = 2'h2;

endpackage : clrc_pkg

// ===== hw/clrc_top.sv
/*
 * Lock, cyclic replacement and ownership for the instruction, data and
 * secondary caches; write buffer accounting for the data and secondary caches.
 * Assumes an APB master, a pipeline issuing one operation per cycle at
 * most, and a system side that drains the write buffers.
 */
`timescale 1ns/1ps
`default_nettype none

module clrc_top
	import clrc_pkg::*;
#(
	parameter int P_DEPTH = CLRC_P_DEPTH,
	parameter int S_DEPTH = CLRC_S_DEPTH
) (
	input  wire  logic        pclk,
	input  wire  logic        presetn,
	input  wire  logic        ce,
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [11:0] paddr,
	input  wire  logic [31:0] pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire  logic        op_valid,
	input  wire  logic [1:0]  op_cache,
	input  wire  clrc_op_type op_kind,
	input  wire  logic [10:0] op_index,
	input  wire  logic [1:0]  op_way,
	input  wire  logic        op_lock_val,
	input  wire  logic [2:0]  op_attr,
	input  wire  logic [1:0]  op_state,
	input  wire  logic        op_dline_dirty,
	input  wire  logic        op_orphan,
	input  wire  logic        unc_store,
	input  wire  logic        unc_to_sys,
	input  wire  logic        pwb_drain,
	input  wire  logic        swb_drain,
	input  wire  logic        sunc_drain,
	output logic              res_valid,
	output logic [1:0]        res_way,
	output logic              res_fill,
	output logic              res_locked,
	output logic              res_owned,
	output logic              res_wb,
	output logic              res_wb_direct,
	output logic              res_skip_l23,
	output logic              res_stall,
	output logic              pwb_busy,
	output logic              swb_full
);

	// ----------------------------------------------------------------
	// Register file over APB
	// ----------------------------------------------------------------
	logic [3:0]  lock_reg;
	logic        acc_reg;
	logic [31:0] rd_next;
	logic        err_next;
	logic [0:0]  pwb_lines_reg;
	logic [2:0]  pwb_unc_reg;
	logic [2:0]  swb_lines_reg;
	logic [2:0]  sunc_reg;

	function automatic logic is_lock_addr(input logic [11:0] a);
		return a == CLRC_LOCK_CTRL_OFF;
	endfunction : is_lock_addr

	// Read mux and unmapped check for the addressed word.
	always_comb begin
		rd_next  = 32'h0000_0000;
		err_next = 1'b0;
		if (is_lock_addr(paddr)) begin
			rd_next[CLRC_SEL_BIT:CLRC_SEN_BIT] = lock_reg;
		end else if (paddr == CLRC_STATUS_OFF) begin
			rd_next[3:0]   = {2'b00, pwb_lines_reg[0], 1'b0};
			rd_next[6:4]   = pwb_unc_reg;
			rd_next[10:8]  = swb_lines_reg;
			rd_next[14:12] = sunc_reg;
		end else begin
			err_next = 1'b1;
		end
	end

	// Answer in the second access cycle, from flip-flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_reg <= 1'b0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			acc_reg <= psel && penable && !pready && !acc_reg;
			pready  <= psel && penable && !pready && !acc_reg;
			pslverr <= psel && penable && !pready && !acc_reg && err_next;
			if (psel && penable && !pready && !acc_reg && !pwrite) begin
				prdata <= rd_next;
			end
		end
	end

	// Lock control register: way select and three enables.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_reg <= CLRC_LOCK_RST;
		end else if (ce && psel && penable && pwrite && pready &&
				is_lock_addr(paddr)) begin
			lock_reg <= pwdata[CLRC_SEL_BIT:CLRC_SEN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Tag state arrays: valid, lock and fill bits per way
	// ----------------------------------------------------------------
	logic [3:0]  cur_v   [3];
	logic [3:0]  cur_l   [3];
	logic [3:0]  cur_f   [3];
	logic [1:0]  way_sel;
	logic        do_fill;
	logic        do_lock;
	logic        lock_en;
	logic        lock_kind;
	logic        locked_hit;
	logic [1:0]  vict;
	logic [3:0]  fv;
	logic [3:0]  fl;
	logic [3:0]  ff;
	logic        ro_sc;
	logic        owned;
	logic        wb_go;
	logic        wb_room;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_cache
			localparam int D = (g == 2) ? S_DEPTH : P_DEPTH;
			localparam int W = $clog2(D);
			logic [3:0] v_mem [D];
			logic [3:0] l_mem [D];
			logic [3:0] f_mem [D];
			logic [W-1:0] idx;
			logic         hit_me;

			assign idx    = op_index[W-1:0];
			assign hit_me = op_valid && op_cache == 2'(g);
			assign cur_v[g] = v_mem[idx];
			assign cur_l[g] = l_mem[idx];
			assign cur_f[g] = f_mem[idx];

			// Each cache keeps its own tag state, so locks are separate.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					for (int i = 0; i < D; i++) begin
						v_mem[i] <= 4'h0;
						l_mem[i] <= 4'h0;
						f_mem[i] <= 4'h0;
					end
				end else if (ce && hit_me) begin
					if (do_fill) begin
						v_mem[idx][way_sel] <= 1'b1;
						l_mem[idx][way_sel] <= do_lock;
						f_mem[idx][way_sel] <= ~f_mem[idx][way_sel];
					end else if (op_kind == CLRC_OP_TAGW) begin
						l_mem[idx][op_way] <= op_lock_val;
					end else if (op_kind == CLRC_OP_INVAL ||
							op_kind == CLRC_OP_WB_INVAL) begin
						v_mem[idx][op_way] <= 1'b0;
						l_mem[idx][op_way] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Round-robin pick from fill bits; locked valid ways are skipped unless all four are, then the base way is taken.
	function automatic logic [1:0] pick_victim(
		input logic [3:0] f,
		input logic [3:0] v,
		input logic [3:0] l
	);
		logic [1:0] base;
		logic [1:0] w;
		base = 2'd0;
		w    = 2'd0;
		for (int i = 3; i >= 1; i--) begin
			if (f[i] != f[i-1]) begin
				base = 2'(i);
			end
		end
		w = base;
		for (int k = 3; k >= 0; k--) begin
			if (!(v[2'(base + 2'(k))] && l[2'(base + 2'(k))])) begin
				w = 2'(base + 2'(k));
			end
		end
		return w;
	endfunction : pick_victim

	// ----------------------------------------------------------------
	// Operation decode
	// ----------------------------------------------------------------
	always_comb begin
		fv = cur_v[op_cache == 2'd3 ? 2'd2 : op_cache];
		fl = cur_l[op_cache == 2'd3 ? 2'd2 : op_cache];
		ff = cur_f[op_cache == 2'd3 ? 2'd2 : op_cache];
		vict = pick_victim(ff, fv, fl);
		// Bypass or uncached pages leave the secondary read-only.
		ro_sc = op_cache == CLRC_SC && (op_attr == CLRC_ATTR_BYP ||
			op_attr == CLRC_ATTR_UNC);
		lock_en = (op_cache == CLRC_IC) ? lock_reg[CLRC_IEN_BIT - 25] :
			(op_cache == CLRC_DC) ? lock_reg[CLRC_DEN_BIT - 25] :
			lock_reg[0];
		lock_kind = (op_cache == CLRC_IC) ? op_kind == CLRC_OP_FILL_I :
			(op_cache == CLRC_DC) ? (op_kind == CLRC_OP_LOAD ||
			op_kind == CLRC_OP_STORE) : (op_kind != CLRC_OP_STHIT &&
			op_kind <= CLRC_OP_FILL_I);
		do_fill = (op_kind == CLRC_OP_LOAD || op_kind == CLRC_OP_STORE ||
			op_kind == CLRC_OP_FILL_I) && !ro_sc &&
			!(op_cache == CLRC_IC && op_kind != CLRC_OP_FILL_I);
		do_lock = lock_en && lock_kind;
		// Locked fills go to way A or B only; half the cache at most.
		way_sel = do_lock ? {1'b0, lock_reg[3]} : vict;
		locked_hit = fv[op_way] && fl[op_way];
		// Ownership follows the line state of the addressed way.
		owned = fv[op_way] && ((op_cache == CLRC_SC) ?
			(op_state == CLRC_S_DEX || op_state == CLRC_S_DEX_D) :
			op_state == CLRC_P_VALID);
		wb_go = (op_kind == CLRC_OP_WB || op_kind == CLRC_OP_WB_INVAL) &&
			owned && op_attr == CLRC_ATTR_WB &&
			!(op_cache == CLRC_SC && op_dline_dirty) &&
			op_cache != CLRC_IC;
		wb_room = (op_cache == CLRC_SC) ?
			swb_lines_reg != 3'(CLRC_SLINE_MAX) :
			!pwb_lines_reg[0] && pwb_unc_reg == 3'd0;
	end

	// ----------------------------------------------------------------
	// Result register toward the pipeline
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_valid     <= 1'b0;
			res_way       <= 2'd0;
			res_fill      <= 1'b0;
			res_locked    <= 1'b0;
			res_owned     <= 1'b0;
			res_wb        <= 1'b0;
			res_wb_direct <= 1'b0;
			res_skip_l23  <= 1'b0;
			res_stall     <= 1'b0;
		end else if (ce) begin
			res_valid     <= op_valid;
			res_way       <= do_fill ? way_sel : op_way;
			res_fill      <= op_valid && do_fill;
			res_locked    <= op_valid && (do_fill ? do_lock : locked_hit);
			res_owned     <= op_valid && owned;
			res_wb        <= op_valid && wb_go && wb_room;
			res_wb_direct <= op_valid && wb_go && wb_room &&
				op_cache == CLRC_DC && op_orphan;
			res_skip_l23  <= op_valid && op_attr == CLRC_ATTR_BYP;
			res_stall     <= op_valid && wb_go && !wb_room;
		end
	end

	// ----------------------------------------------------------------
	// Write buffer occupancy
	// ----------------------------------------------------------------
	logic       wb_push;

	assign wb_push = ce && op_valid && wb_go && wb_room;

	// Primary buffer holds one data line or up to four stores.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwb_lines_reg <= 1'b0;
			pwb_unc_reg   <= 3'd0;
		end else if (ce) begin
			if (pwb_drain) begin
				pwb_lines_reg <= 1'b0;
				pwb_unc_reg   <= 3'd0;
			end else if (wb_push && op_cache == CLRC_DC) begin
				pwb_lines_reg <= 1'b1;
			end else if (unc_store && !unc_to_sys && !pwb_lines_reg[0] &&
					pwb_unc_reg != 3'(CLRC_UNC_MAX)) begin
				pwb_unc_reg <= pwb_unc_reg + 3'd1;
			end
		end
	end

	// Four secondary line slots and one store slot of four.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swb_lines_reg <= 3'd0;
			sunc_reg      <= 3'd0;
		end else if (ce) begin
			if (wb_push && op_cache == CLRC_SC && !swb_drain) begin
				swb_lines_reg <= swb_lines_reg + 3'd1;
			end else if (swb_drain && !(wb_push && op_cache == CLRC_SC) &&
					swb_lines_reg != 3'd0) begin
				swb_lines_reg <= swb_lines_reg - 3'd1;
			end
			if (sunc_drain) begin
				sunc_reg <= 3'd0;
			end else if (unc_store && unc_to_sys &&
					sunc_reg != 3'(CLRC_UNC_MAX)) begin
				sunc_reg <= sunc_reg + 3'd1;
			end
		end
	end

	// Busy and full flags registered for the pipeline.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwb_busy <= 1'b0;
			swb_full <= 1'b0;
		end else if (ce) begin
			pwb_busy <= pwb_lines_reg[0] || pwb_unc_reg == 3'(CLRC_UNC_MAX);
			swb_full <= swb_lines_reg == 3'(CLRC_SLINE_MAX);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	lock_way_a: assert property (ce && op_valid && do_fill && do_lock |=>
		res_way == {1'b0, $past(lock_reg[3])} && res_locked)
		else $error("locked fill not in selected way");
	no_lock_vict_a: assert property (ce && op_valid && do_fill && !do_lock
		|-> !(fv[way_sel] && fl[way_sel]))
		else $error("victim is a locked valid way");
	byp_skip_a: assert property (ce && op_valid && op_attr == CLRC_ATTR_BYP
		|=> res_skip_l23)
		else $error("bypass attribute not flagged");
	sc_ro_a: assert property (ce && op_valid && ro_sc |=> !res_fill && !res_wb)
		else $error("read-only secondary was written");
	sc_dirty_a: assert property (ce && op_valid && op_cache == CLRC_SC &&
		op_dline_dirty |=> !res_wb)
		else $error("secondary written back over dirty data line");
	orphan_a: assert property (res_wb_direct |-> res_wb)
		else $error("direct writeback without writeback");
	pwb_one_a: assert property (pwb_lines_reg[0] |-> pwb_unc_reg == 3'd0)
		else $error("primary buffer mixes line and stores");
	swb_max_a: assert property (swb_lines_reg <= 3'(CLRC_SLINE_MAX) &&
		sunc_reg <= 3'(CLRC_UNC_MAX))
		else $error("secondary buffer over capacity");
	lock_bits_a: assert property (do_lock && do_fill |-> !way_sel[1])
		else $error("way select out of range");
	apb_rdy_a: assert property (psel && penable && !pready && !acc_reg && ce
		|=> pready ##1 !pready)
		else $error("APB answer timing broken");

	locked_fill_c: cover property (ce && op_valid && do_fill && do_lock);
	wb_c: cover property (res_wb ##1 res_wb_direct);
	stall_c: cover property (res_stall);

endmodule : clrc_top

`default_nettype wire

// ===== verification/clrc_sys_model.sv
/*
 * System side model that drains the write buffers.
 * Assumes one clock; hold stalls the drains to let buffers fill.
 */
`timescale 1ns/1ps
`default_nettype none

module clrc_sys_model #(
	parameter int GAP = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic hold,
	input  wire logic pwb_busy,
	output logic      pwb_drain,
	output logic      swb_drain,
	output logic      sunc_drain
);

	int unsigned cnt;

	// Every GAP+1 cycles one drain pulse per buffer, the primary only when busy, unless stalled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			pwb_drain <= 1'b0;
			swb_drain <= 1'b0;
			sunc_drain <= 1'b0;
		end else if (cnt == GAP && !hold) begin
			cnt <= 0;
			pwb_drain <= pwb_busy;
			swb_drain <= 1'b1;
			sunc_drain <= 1'b1;
		end else begin
			cnt <= (cnt == GAP) ? cnt : cnt + 1;
			pwb_drain <= 1'b0;
			swb_drain <= 1'b0;
			sunc_drain <= 1'b0;
		end
	end

endmodule : clrc_sys_model

`default_nettype wire

// ===== verification/clrc_top_bench.sv
/*
 * Self-checking bench for the cache lock and replacement controller.
 * Assumes the system model drains the buffers whenever not held.
 */
`timescale 1ns/1ps
`default_nettype none

module clrc_top_bench
	import clrc_pkg::*;
;

	typedef struct packed {
		logic [3:0]  lk;
		logic [1:0]  c;
		clrc_op_type k;
		logic [10:0] i;
		logic [1:0]  w;
		logic [2:0]  a;
		logic [1:0]  s;
		logic [1:0]  dor;
		logic [6:0]  e;
	} clrc_row_type;

	logic         pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic         op_valid, op_lock_val, op_dline_dirty, op_orphan, er;
	logic [1:0]   op_cache, op_way, op_state, res_way;
	clrc_op_type  op_kind;
	logic [10:0]  op_index;
	logic [2:0]   op_attr;
	logic         unc_store, unc_to_sys, hold, pwb_busy, swb_full;
	logic         pwb_drain, swb_drain, sunc_drain, res_valid, res_fill;
	logic         res_locked, res_owned, res_wb, res_wb_direct;
	logic         res_skip_l23, res_stall;
	int           fail_count, checks_done, n;
	clrc_row_type rows [25];

	clrc_top #(.S_DEPTH(128)) u_clrc_top (.pclk, .presetn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.op_valid, .op_cache, .op_kind, .op_index, .op_way, .op_lock_val,
		.op_attr, .op_state, .op_dline_dirty, .op_orphan, .unc_store,
		.unc_to_sys, .pwb_drain, .swb_drain, .sunc_drain, .res_valid,
		.res_way, .res_fill, .res_locked, .res_owned, .res_wb,
		.res_wb_direct, .res_skip_l23, .res_stall, .pwb_busy, .swb_full);

	clrc_sys_model u_clrc_sys_model (.pclk, .presetn, .hold, .pwb_busy,
		.pwb_drain, .swb_drain, .sunc_drain);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
			fail_count++;
		end
	endtask : chk

	// One APB transfer; pready is looked at just before each edge.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20) begin
			fail_count++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// One pipeline operation; results are read in the following cycle.
	task automatic issue(input clrc_row_type r);
		@(posedge pclk);
		op_valid <= 1'b1;
		op_cache <= r.c;
		op_kind <= r.k;
		op_index <= r.i;
		op_way <= r.w;
		op_attr <= r.a;
		op_state <= r.s;
		op_lock_val <= r.dor[1];
		op_dline_dirty <= r.dor[1];
		op_orphan <= r.dor[0];
		@(posedge pclk);
		op_valid <= 1'b0;
		@(negedge pclk);
	endtask : issue

	task automatic wait_empty();
		int k;
		for (k = 0; k < 300 && (pwb_busy !== 1'b0 || swb_full !== 1'b0); k++)
			@(negedge pclk);
		if (k == 300) begin
			fail_count++;
			end_of_test();
		end
	endtask : wait_empty

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Cuts a hung run short.
	initial begin
		repeat (100000) @(posedge pclk);
		fail_count++;
		end_of_test();
	end

	// Expected e: way, locked, owned, writeback, direct, skip.
	initial begin
		rows = '{
		'{4'h0, CLRC_DC, CLRC_OP_LOAD, 11'h005, 2'h0, 3'h3, 2'h0, 2'h0, 7'h00},
		'{4'h0, CLRC_DC, CLRC_OP_LOAD, 11'h005, 2'h0, 3'h3, 2'h0, 2'h0, 7'h20},
		'{4'h0, CLRC_DC, CLRC_OP_LOAD, 11'h005, 2'h0, 3'h3, 2'h0, 2'h0, 7'h40},
		'{4'h0, CLRC_DC, CLRC_OP_LOAD, 11'h005, 2'h0, 3'h3, 2'h0, 2'h0, 7'h60},
		'{4'h0, CLRC_DC, CLRC_OP_LOAD, 11'h005, 2'h0, 3'h3, 2'h0, 2'h0, 7'h00},
		'{4'hA, CLRC_DC, CLRC_OP_LOAD, 11'h006, 2'h0, 3'h3, 2'h0, 2'h0, 7'h30},
		'{4'h0, CLRC_DC, CLRC_OP_LOAD, 11'h006, 2'h0, 3'h3, 2'h0, 2'h0, 7'h40},
		'{4'h0, CLRC_DC, CLRC_OP_STHIT, 11'h006, 2'h1, 3'h3, 2'h0, 2'h0, 7'h30},
		'{4'h0, CLRC_DC, CLRC_OP_INVAL, 11'h006, 2'h1, 3'h3, 2'h0, 2'h0, 7'h30},
		'{4'h0, CLRC_DC, CLRC_OP_LOAD, 11'h006, 2'h0, 3'h3, 2'h0, 2'h0, 7'h20},
		'{4'h9, CLRC_SC, CLRC_OP_LOAD, 11'h009, 2'h0, 3'h3, 2'h0, 2'h0, 7'h30},
		'{4'hC, CLRC_IC, CLRC_OP_LOAD, 11'h003, 2'h0, 3'h3, 2'h0, 2'h0, 7'h00},
		'{4'hC, CLRC_IC, CLRC_OP_FILL_I, 11'h004, 2'h0, 3'h3, 2'h0, 2'h0, 7'h30},
		'{4'h0, CLRC_IC, CLRC_OP_TAGW, 11'h004, 2'h1, 3'h3, 2'h0, 2'h0, 7'h30},
		'{4'h4, CLRC_DC, CLRC_OP_LOAD, 11'h007, 2'h0, 3'h3, 2'h0, 2'h0, 7'h00},
		'{4'hA, CLRC_DC, CLRC_OP_STORE, 11'h00C, 2'h0, 3'h3, 2'h0, 2'h0, 7'h30},
		'{4'h0, CLRC_DC, CLRC_OP_TAGW, 11'h00C, 2'h2, 3'h3, 2'h0, 2'h2, 7'h40},
		'{4'h0, CLRC_DC, CLRC_OP_LOAD, 11'h008, 2'h0, 3'h7, 2'h0, 2'h0, 7'h01},
		'{4'h0, CLRC_DC, CLRC_OP_WB, 11'h005, 2'h2, 3'h3, 2'h3, 2'h0, 7'h4C},
		'{4'h0, CLRC_DC, CLRC_OP_WB, 11'h005, 2'h3, 3'h3, 2'h3, 2'h1, 7'h6E},
		'{4'h0, CLRC_SC, CLRC_OP_WB, 11'h009, 2'h1, 3'h3, 2'h3, 2'h2, 7'h38},
		'{4'h0, CLRC_SC, CLRC_OP_WB, 11'h009, 2'h1, 3'h2, 2'h2, 2'h0, 7'h38},
		'{4'h0, CLRC_SC, CLRC_OP_WB, 11'h009, 2'h1, 3'h3, 2'h2, 2'h0, 7'h3C},
		'{4'h0, CLRC_SC, CLRC_OP_WB_INVAL, 11'h00A, 2'h0, 3'h3, 2'h0, 2'h0,
			7'h00},
		'{4'h0, CLRC_IC, CLRC_OP_WB, 11'h004, 2'h1, 3'h3, 2'h3, 2'h0, 7'h28}};
		{psel, penable, pwrite, paddr, pwdata, op_valid, op_cache} = '0;
		{op_way, op_attr, op_state, op_index, op_lock_val} = '0;
		{op_dline_dirty, op_orphan, unc_store, unc_to_sys, hold} = '0;
		op_kind = CLRC_OP_LOAD;
		ce = 1'b1;
		presetn = 1'b0;
		fail_count = 0;
		checks_done = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CLRC_LOCK_CTRL_OFF, 32'h0000_0000);
		chk("lock_rst", rd, 32'h0000_0000);
		apb(1'b1, CLRC_LOCK_CTRL_OFF, 32'hFFFF_FFFF);
		apb(1'b0, CLRC_LOCK_CTRL_OFF, 32'h0000_0000);
		chk("lock_rw", rd, 32'h1E00_0000);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		chk("unmapped_err", er, 1'b1);
		for (n = 0; n < 25; n++) begin
			// Let the previous writeback reach the busy flag and drain.
			repeat (2) @(negedge pclk);
			wait_empty();
			apb(1'b1, CLRC_LOCK_CTRL_OFF, {3'h0, rows[n].lk, 25'h0});
			issue(rows[n]);
			chk("way", {res_valid, res_way}, {1'b1, rows[n].e[6:5]});
			chk("lock", res_locked, rows[n].e[4]);
			chk("own", res_owned, rows[n].e[3]);
			chk("wb", {res_wb, res_stall}, {rows[n].e[2], 1'b0});
			chk("direct", res_wb_direct, rows[n].e[1]);
			chk("skip", res_skip_l23, rows[n].e[0]);
		end
		// Secondary line buffers fill while the system side stalls.
		wait_empty();
		repeat (8) @(posedge pclk);
		hold <= 1'b1;
		repeat (6) @(posedge pclk);
		for (n = 0; n < 5; n++) begin
			issue('{4'h0, CLRC_SC, CLRC_OP_WB, 11'h009, 2'h1, 3'h3, 2'h3,
				2'h0, 7'h00});
			chk("swb", {res_wb, res_stall}, (n < 4) ? 2'h2 : 2'h1);
		end
		chk("swb_full", swb_full, 1'b1);
		// Four uncached stores to the primary buffer, one to the system.
		@(posedge pclk);
		unc_store <= 1'b1;
		repeat (4) @(posedge pclk);
		unc_to_sys <= 1'b1;
		@(posedge pclk);
		unc_store <= 1'b0;
		unc_to_sys <= 1'b0;
		apb(1'b0, CLRC_STATUS_OFF, 32'h0000_0000);
		chk("status", rd, 32'h0000_1440);
		issue('{4'h0, CLRC_DC, CLRC_OP_WB, 11'h005, 2'h0, 3'h3, 2'h3, 2'h0,
			7'h00});
		chk("pwb", {res_wb, res_stall}, 2'h1);
		hold <= 1'b0;
		wait_empty();
		// A reset in mid-run clears the lock register and the tags.
		apb(1'b1, CLRC_LOCK_CTRL_OFF, 32'h0400_0000);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CLRC_LOCK_CTRL_OFF, 32'h0000_0000);
		chk("lock_rst2", rd, 32'h0000_0000);
		issue('{4'h0, CLRC_DC, CLRC_OP_LOAD, 11'h006, 2'h0, 3'h3, 2'h0, 2'h0,
			7'h00});
		chk("tag_rst", {res_way, res_locked}, 3'h0);
		end_of_test();
	end

endmodule : clrc_top_bench

`default_nettype wire
